// ### scr_timer.sv
// Notes on behaviour
// - split and capture off: one 16-bit timer, wrap loads reload, sets high flag.
// - with interrupts enabled, every 16-bit overflow raises the interrupt request.
// - 16-bit mode with low interrupt enable: low byte wrap also interrupts.
// - split mode: two 8-bit timers, each reloads from its own reload byte, or wraps to zero with capture on.
// - run bit gates whole timer in 16-bit mode, only high byte in split.
// - per byte in split, low byte only in 16-bit mode: system clock if select set, else clock/12 or external/8.
// - external divided-by-eight tick is synchronised before it advances the counter.
// - split: high wrap sets high flag, low wrap sets low flag; interrupts follow.
// - flags are never cleared by hardware; software clears and inspects both.
// - low flag sets on every low byte wrap, in every mode.
// - capture, no split: 16-bit count copied into reload pair on each frame start.
// - capture with split: bytes count independently, both latched on frame start.
// - split bit 3 and capture bit 4 of the control register pick the mode.
// - reload pair supplies reload values, or holds captured counter bytes.
// - control bit 1 reads zero, writes to it are ignored.
// - both counter bytes are readable and writable registers.
module scr_timer (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       int_enable,
  input  wire logic       high_byte_system_clock_select,
  input  wire logic       low_byte_system_clock_select,
  input  wire logic       ext_osc_div8,
  input  wire logic       sof_pulse,
  output logic            irq_req
);
  import scr_pkg::*;

  scr_state_t st_q;
  scr_state_t st_d;

  logic       tick12;
  logic       ext_tick;
  logic       ext_sel;
  logic       tick_lo;
  logic       tick_hi;
  logic       run;
  logic       split;
  logic       capture;
  logic       inc_lo;
  logic       inc_hi;
  logic       set_h;
  logic       set_l;
  logic       wr_ctrl;
  logic       wr_rl_lo;
  logic       wr_rl_hi;
  logic       wr_cnt_lo;
  logic       wr_cnt_hi;
  logic       wr_any_cnt;
  logic [7:0] rl_lo_nx;
  logic [7:0] rl_hi_nx;

  // mode and clock source decode from the control register
  assign run     = st_q.ctrl[CTRL_RUN];
  assign split   = st_q.ctrl[CTRL_SPLIT];
  assign capture = st_q.ctrl[CTRL_SOF];
  assign ext_sel = st_q.ctrl[CTRL_XCLK];

  // system clock / 12 enable, one cycle wide
  assign tick12 = (st_q.div == DIV_LAST);

  // rising edge of the synchronised external tick, taken after two flops
  assign ext_tick = st_q.sync[1] & ~st_q.sync[2];

  // per byte clock choice
  assign tick_lo = low_byte_system_clock_select ? 1'b1
                 : (ext_sel ? ext_tick : tick12);
  assign tick_hi = high_byte_system_clock_select ? 1'b1
                 : (ext_sel ? ext_tick : tick12);

  // run gating: whole timer in 16-bit mode, only high byte in split
  assign inc_lo = split ? tick_lo : (run & tick_lo);
  assign inc_hi = split & run & tick_hi;

  // register write strobes
  assign wr_ctrl    = sfr_wr & (sfr_addr == ADDR_CTRL);
  assign wr_rl_lo   = sfr_wr & (sfr_addr == ADDR_RL_LO);
  assign wr_rl_hi   = sfr_wr & (sfr_addr == ADDR_RL_HI);
  assign wr_cnt_lo  = sfr_wr & (sfr_addr == ADDR_CNT_LO);
  assign wr_cnt_hi  = sfr_wr & (sfr_addr == ADDR_CNT_HI);
  assign wr_any_cnt = wr_cnt_lo | wr_cnt_hi;

  // reload pair after software writes, before frame capture
  assign rl_lo_nx = wr_rl_lo ? sfr_wdata : st_q.rl_lo;
  assign rl_hi_nx = wr_rl_hi ? sfr_wdata : st_q.rl_hi;

  // next state of the whole timer
  always_comb begin
    st_d = st_q;
    set_h = 1'b0;
    set_l = 1'b0;
    st_d.sync = {st_q.sync[1:0], ext_osc_div8};
    st_d.div  = tick12 ? DIV_ZERO : (st_q.div + DIV_ONE);

    if (!split) begin
      // one 16-bit counter, low byte carries into high byte
      if (inc_lo) begin
        if (st_q.cnt_lo == BYTE_MAX) begin
          set_l = 1'b1;
          if (st_q.cnt_hi == BYTE_MAX) begin
            set_h = 1'b1;
            if (capture) begin
              st_d.cnt_lo = BYTE_ZERO;
              st_d.cnt_hi = BYTE_ZERO;
            end else begin
              st_d.cnt_lo = st_q.rl_lo;
              st_d.cnt_hi = st_q.rl_hi;
            end
          end else begin
            st_d.cnt_lo = BYTE_ZERO;
            st_d.cnt_hi = st_q.cnt_hi + BYTE_ONE;
          end
        end else begin
          st_d.cnt_lo = st_q.cnt_lo + BYTE_ONE;
        end
      end
    end else begin
      // two independent 8-bit counters
      if (inc_lo) begin
        if (st_q.cnt_lo == BYTE_MAX) begin
          set_l = 1'b1;
          st_d.cnt_lo = capture ? BYTE_ZERO : st_q.rl_lo;
        end else begin
          st_d.cnt_lo = st_q.cnt_lo + BYTE_ONE;
        end
      end
      if (inc_hi) begin
        if (st_q.cnt_hi == BYTE_MAX) begin
          set_h = 1'b1;
          st_d.cnt_hi = capture ? BYTE_ZERO : st_q.rl_hi;
        end else begin
          st_d.cnt_hi = st_q.cnt_hi + BYTE_ONE;
        end
      end
    end

    // frame start in capture mode takes a request on the high flag
    if (capture && sof_pulse) begin
      set_h = 1'b1;
    end

    // software writes to the counter bytes override counting
    if (wr_cnt_lo) begin
      st_d.cnt_lo = sfr_wdata;
    end
    if (wr_cnt_hi) begin
      st_d.cnt_hi = sfr_wdata;
    end

    // reload pair: software value, replaced by a capture on frame start
    st_d.rl_lo = rl_lo_nx;
    st_d.rl_hi = rl_hi_nx;
    if (capture && sof_pulse) begin
      st_d.rl_lo = st_q.cnt_lo;
      st_d.rl_hi = st_q.cnt_hi;
    end

    // control write; bit 1 stays zero, hardware set beats a clear
    if (wr_ctrl) begin
      st_d.ctrl = sfr_wdata & CTRL_WMASK;
    end
    st_d.ctrl[CTRL_TFH] = st_d.ctrl[CTRL_TFH] | set_h;
    st_d.ctrl[CTRL_TFL] = st_d.ctrl[CTRL_TFL] | set_l;

    // interrupt request from the flags and enables
    st_d.irq = int_enable & (st_q.ctrl[CTRL_TFH]
             | (st_q.ctrl[CTRL_TFL] & st_q.ctrl[CTRL_LEN]));

    // registered read data, zero for unmapped addresses
    st_d.rdata = st_q.rdata;
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_CTRL:   st_d.rdata = st_q.ctrl & CTRL_WMASK;
        ADDR_RL_LO:  st_d.rdata = st_q.rl_lo;
        ADDR_RL_HI:  st_d.rdata = st_q.rl_hi;
        ADDR_CNT_LO: st_d.rdata = st_q.cnt_lo;
        ADDR_CNT_HI: st_d.rdata = st_q.cnt_hi;
        default:     st_d.rdata = BYTE_ZERO;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '{ctrl: CTRL_RESET, rl_lo: BYTE_RESET, rl_hi: BYTE_RESET,
                cnt_lo: BYTE_RESET, cnt_hi: BYTE_RESET, div: DIV_ZERO,
                sync: SYNC_RESET, rdata: BYTE_RESET, irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign sfr_rdata = st_q.rdata;
  assign irq_req   = st_q.irq;

  // checks on the timer behaviour

  a_wrap_reload: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!split && !capture && inc_lo && !wr_any_cnt && !wr_ctrl
      && st_q.cnt_lo == BYTE_MAX && st_q.cnt_hi == BYTE_MAX)
    |=> (st_q.cnt_lo == $past(st_q.rl_lo) && st_q.cnt_hi == $past(st_q.rl_hi)
      && st_q.ctrl[CTRL_TFH])
  ) else $error("16-bit wrap did not reload or set high flag");

  a_irq_high_flag: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q.ctrl[CTRL_TFH] && int_enable) |=> irq_req
  ) else $error("high flag with interrupts enabled gave no request");

  a_irq_low_byte: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q.ctrl[CTRL_TFL] && st_q.ctrl[CTRL_LEN] && int_enable) |=> irq_req
  ) else $error("low flag with low enable gave no request");

  a_irq_masked: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!int_enable || (!st_q.ctrl[CTRL_TFH]
      && !(st_q.ctrl[CTRL_TFL] && st_q.ctrl[CTRL_LEN]))) |=> !irq_req
  ) else $error("interrupt request without enabled cause");

  a_split_low_reload: assert property (
    @(posedge clk) disable iff (!reset_n)
    (split && !capture && inc_lo && !wr_cnt_lo && !wr_ctrl
      && st_q.cnt_lo == BYTE_MAX)
    |=> st_q.cnt_lo == $past(st_q.rl_lo)
  ) else $error("split low byte did not reload");

  a_split_high_reload: assert property (
    @(posedge clk) disable iff (!reset_n)
    (split && !capture && inc_hi && !wr_cnt_hi && !wr_ctrl
      && st_q.cnt_hi == BYTE_MAX)
    |=> (st_q.cnt_hi == $past(st_q.rl_hi) && st_q.ctrl[CTRL_TFH])
  ) else $error("split high byte did not reload or flag");

  a_run_stopped: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!run && !wr_any_cnt && !wr_ctrl)
    |=> ($stable(st_q.cnt_hi) && ($past(split) || $stable(st_q.cnt_lo)))
  ) else $error("counter moved while stopped");

  a_split_low_free: assert property (
    @(posedge clk) disable iff (!reset_n)
    (split && !run && tick_lo && !wr_cnt_lo && !wr_ctrl
      && st_q.cnt_lo != BYTE_MAX)
    |=> st_q.cnt_lo == $past(st_q.cnt_lo) + BYTE_ONE
  ) else $error("split low byte did not run freely");

  a_div12_period: assert property (
    @(posedge clk) disable iff (!reset_n)
    tick12 |=> (!tick12 ##11 tick12)
  ) else $error("prescaler period is not twelve cycles");

  a_ext_sync: assert property (
    @(posedge clk) disable iff (!reset_n)
    ext_tick |-> ($past(ext_osc_div8, 2) && !$past(ext_osc_div8, 3))
  ) else $error("external tick not from a synchronised edge");

  a_high_flag_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q.ctrl[CTRL_TFH] && !(wr_ctrl && !sfr_wdata[CTRL_TFH]))
    |=> st_q.ctrl[CTRL_TFH]
  ) else $error("high flag cleared by hardware");

  a_low_flag_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_q.ctrl[CTRL_TFL] && !(wr_ctrl && !sfr_wdata[CTRL_TFL]))
    |=> st_q.ctrl[CTRL_TFL]
  ) else $error("low flag cleared by hardware");

  a_low_wrap_flag: assert property (
    @(posedge clk) disable iff (!reset_n)
    (inc_lo && st_q.cnt_lo == BYTE_MAX) |=> st_q.ctrl[CTRL_TFL]
  ) else $error("low byte wrap did not set low flag");

  a_frame_capture: assert property (
    @(posedge clk) disable iff (!reset_n)
    (capture && sof_pulse)
    |=> (st_q.rl_lo == $past(st_q.cnt_lo) && st_q.rl_hi == $past(st_q.cnt_hi)
      && st_q.ctrl[CTRL_TFH])
  ) else $error("frame start did not capture the count");

  a_capture_no_load: assert property (
    @(posedge clk) disable iff (!reset_n)
    (capture && !split && inc_lo && !wr_any_cnt && !wr_ctrl
      && st_q.cnt_lo == BYTE_MAX && st_q.cnt_hi == BYTE_MAX)
    |=> (st_q.cnt_lo == BYTE_ZERO && st_q.cnt_hi == BYTE_ZERO)
  ) else $error("capture mode wrap loaded the reload pair");

  a_unused_bit: assert property (
    @(posedge clk) disable iff (!reset_n)
    (sfr_rd && sfr_addr == ADDR_CTRL) |=> !sfr_rdata[1]
  ) else $error("unused control bit read as one");

  a_count_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    (sfr_rd && sfr_addr == ADDR_CNT_HI) |=> sfr_rdata == $past(st_q.cnt_hi)
  ) else $error("high count read returned wrong value");

  a_high_carry: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!split && inc_lo && !wr_any_cnt && st_q.cnt_lo == BYTE_MAX
      && st_q.cnt_hi != BYTE_MAX)
    |=> (st_q.cnt_lo == BYTE_ZERO && st_q.cnt_hi == $past(st_q.cnt_hi) + BYTE_ONE)
  ) else $error("low byte wrap did not carry into high byte");

  a_system_clock_low_tick: assert property (
    @(posedge clk) disable iff (!reset_n)
    (split && low_byte_system_clock_select && !wr_cnt_lo && st_q.cnt_lo != BYTE_MAX)
    |=> st_q.cnt_lo == $past(st_q.cnt_lo) + BYTE_ONE
  ) else $error("system clock select did not count every cycle");

  a_high_wrap_flag: assert property (
    @(posedge clk) disable iff (!reset_n)
    (split && inc_hi && st_q.cnt_hi == BYTE_MAX) |=> st_q.ctrl[CTRL_TFH]
  ) else $error("high byte wrap did not set high flag");

  a_split_cap_wrap: assert property (
    @(posedge clk) disable iff (!reset_n)
    (split && capture && inc_lo && !wr_cnt_lo && st_q.cnt_lo == BYTE_MAX)
    |=> st_q.cnt_lo == BYTE_ZERO
  ) else $error("split capture low byte did not wrap to zero");

  a_mode_select: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_ctrl |=> (split == $past(sfr_wdata[CTRL_SPLIT])
      && capture == $past(sfr_wdata[CTRL_SOF]))
  ) else $error("control write did not set the mode bits");

  a_reload_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_rl_lo && !(capture && sof_pulse)) |=> st_q.rl_lo == $past(sfr_wdata)
  ) else $error("reload low write did not land");

endmodule

// ### scr_pkg.sv
package scr_pkg;

  // register addresses on the special function register bus
  localparam logic [7:0] ADDR_CTRL   = 8'h91;
  localparam logic [7:0] ADDR_RL_LO  = 8'h92;
  localparam logic [7:0] ADDR_RL_HI  = 8'h93;
  localparam logic [7:0] ADDR_CNT_LO = 8'h94;
  localparam logic [7:0] ADDR_CNT_HI = 8'h95;

  // timer_control field positions
  localparam int CTRL_TFH   = 7;  // high_overflow_flag
  localparam int CTRL_TFL   = 6;  // low_overflow_flag
  localparam int CTRL_LEN   = 5;  // low_byte_irq_enable
  localparam int CTRL_SOF   = 4;  // frame_capture_enable
  localparam int CTRL_SPLIT = 3;  // split_mode_enable
  localparam int CTRL_RUN   = 2;  // run_control
  localparam int CTRL_XCLK  = 0;  // external_tick_select

  // writable bits of timer_control; bit 1 is unused
  localparam logic [7:0] CTRL_WMASK = 8'hfd;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // byte limits
  localparam logic [7:0] BYTE_MAX  = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE  = 8'h01;

  // system clock prescaler
  localparam int         SYS_DIV     = 12;
  localparam logic [3:0] DIV_LAST    = 4'(SYS_DIV - 1);
  localparam logic [3:0] DIV_ZERO    = 4'h0;
  localparam logic [3:0] DIV_ONE     = 4'h1;

  // external oscillator divide, done before this block
  localparam int EXT_DIV = 8;

  // synchroniser stages plus edge reference
  localparam int         SYNC_W     = 3;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  // whole state of the timer
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rl_lo;
    logic [7:0] rl_hi;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [3:0] div;
    logic [2:0] sync;
    logic [7:0] rdata;
    logic       irq;
  } scr_state_t;

endpackage

// ### scr_osc_model.sv
module scr_osc_model (
  input  wire logic burst,
  output logic      ext_osc_div8
);
  timeunit 1ns;
  timeprecision 1ps;

  // oscillator idles low between bursts
  initial ext_osc_div8 = 1'b0;

  // five slow periods per burst; edges never land on a rising system clock edge
  always @(posedge burst) begin
    repeat (5) begin
      #24 ext_osc_div8 = 1'b1;
      #30 ext_osc_div8 = 1'b0;
    end
  end
endmodule

// ### sof_capture_reload_timer_tb.sv
module sof_capture_reload_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scr_pkg::*;

  logic       clk;
  logic       reset_n;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       int_enable;
  logic       hsel;
  logic       lsel;
  logic       ext_osc_div8;
  logic       sof_pulse;
  logic       irq_req;
  logic       burst;
  int         fails;
  int         comparisons;

  scr_timer dut_u (
    .clk                     (clk),
    .reset_n                 (reset_n),
    .sfr_addr                (sfr_addr),
    .sfr_wr                  (sfr_wr),
    .sfr_rd                  (sfr_rd),
    .sfr_wdata               (sfr_wdata),
    .sfr_rdata               (sfr_rdata),
    .int_enable              (int_enable),
    .high_byte_system_clock_select (hsel),
    .low_byte_system_clock_select  (lsel),
    .ext_osc_div8            (ext_osc_div8),
    .sof_pulse               (sof_pulse),
    .irq_req                 (irq_req)
  );

  scr_osc_model osc_u (
    .burst        (burst),
    .ext_osc_div8 (ext_osc_div8)
  );

  // 100 MHz system clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic final_report;
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // byte and flag comparisons
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: irq got %b expected %b", $time, got, exp);
    end
  endtask

  // register bus cycles, driven at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    cmp8(sfr_rdata, x);
    sfr_rd = 1'b0;
  endtask

  // load, run from edge e0, read ctrl/low/high at e4/e6/e8, frame start at e10
  task automatic run_case(input logic [15:0] cnt, input logic [15:0] rl,
                          input logic [7:0] ctrl, input logic [7:0] xctrl,
                          input logic [7:0] xlo, input logic [7:0] xhi,
                          input logic [15:0] xrl, input logic xirq);
    wr(ADDR_CNT_LO, cnt[7:0]);
    wr(ADDR_CNT_HI, cnt[15:8]);
    wr(ADDR_RL_LO, rl[7:0]);
    wr(ADDR_RL_HI, rl[15:8]);
    wr(ADDR_CTRL, ctrl);
    repeat (2) @(negedge clk);
    chk(ADDR_CTRL, xctrl);
    chk(ADDR_CNT_LO, xlo);
    chk(ADDR_CNT_HI, xhi);
    cmp1(irq_req, xirq);
    @(negedge clk);
    sof_pulse = 1'b1;
    @(negedge clk);
    sof_pulse = 1'b0;
    chk(ADDR_RL_LO, xrl[7:0]);
    chk(ADDR_RL_HI, xrl[15:8]);
    wr(ADDR_CTRL, 8'h00);
  endtask

  // hang guard, far beyond the roughly four hundred cycles of the run
  initial begin
    #500000;
    fails++;
    final_report();
  end

  // main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    reset_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    int_enable = 1'b1;
    hsel = 1'b1;
    lsel = 1'b1;
    sof_pulse = 1'b0;
    burst = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    for (int a = 8'h90; a <= 8'h96; a++) begin
      chk(8'(a), 8'h00);
    end
    wr(ADDR_CTRL, 8'h02);
    chk(ADDR_CTRL, 8'h00);
    wr(8'h96, 8'h5a);
    chk(8'h96, 8'h00);
    run_case(16'hfffe, 16'h1234, 8'h04, 8'hc4, 8'h37, 8'h12, 16'h1234, 1'b1);
    run_case(16'h00fe, 16'h0000, 8'h24, 8'h64, 8'h03, 8'h01, 16'h0000, 1'b1);
    run_case(16'h00fe, 16'h0000, 8'h04, 8'h44, 8'h03, 8'h01, 16'h0000, 1'b0);
    run_case(16'hfffe, 16'h5520, 8'h08, 8'h48, 8'h23, 8'hff, 16'h5520, 1'b0);
    run_case(16'hfffe, 16'h5520, 8'h2c, 8'hec, 8'h23, 8'h5b, 16'h5520, 1'b1);
    run_case(16'hfffe, 16'h1234, 8'h14, 8'hd4, 8'h03, 8'h00, 16'h0007, 1'b1);
    run_case(16'hfffe, 16'h1234, 8'h1c, 8'hdc, 8'h03, 8'h06, 16'h0807, 1'b1);
    // interrupts masked: flags still set, no request
    int_enable = 1'b0;
    run_case(16'hfffe, 16'h1234, 8'h04, 8'hc4, 8'h37, 8'h12, 16'h1234, 1'b0);
    int_enable = 1'b1;
    // divide by 12: exactly ten ticks in 120 cycles
    lsel = 1'b0;
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CTRL, 8'h04);
    repeat (119) @(negedge clk);
    chk(ADDR_CNT_LO, 8'h0a);
    wr(ADDR_CTRL, 8'h00);
    // external ticks: five oscillator edges give five counts
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CTRL, 8'h05);
    burst = 1'b1;
    repeat (40) @(negedge clk);
    chk(ADDR_CNT_LO, 8'h05);
    final_report();
  end
endmodule
